// file: clkmg_regs.svh
`ifndef CLKMG_REGS_SVH
`define CLKMG_REGS_SVH
// apb register byte offsets
`define CLKMG_OFF_CTRL      12'h000
`define CLKMG_OFF_STATUS    12'h004
`define CLKMG_OFF_PS        12'h008
`define CLKMG_OFF_CFG_ADDR  12'h00C
`define CLKMG_OFF_CFG_DATA  12'h010
`define CLKMG_OFF_PHASE     12'h014
// ctrl fields
`define CLKMG_CTRL_RST      0
`define CLKMG_CTRL_SEL      1
`define CLKMG_CTRL_FBSTOP   2
`define CLKMG_CTRL_INSTOP   3
// ps register fields
`define CLKMG_PS_START      0
`define CLKMG_PS_DIR        1
// status fields
`define CLKMG_ST_LOCK       0
`define CLKMG_ST_INSTOP     1
`define CLKMG_ST_FBSTOP     2
`define CLKMG_ST_PSBUSY     3
`define CLKMG_ST_RDY        4
// cfg addr fields
`define CLKMG_CA_WRITE      8
`define CLKMG_CA_GO         9
// config word addresses
`define CLKMG_CW_OUT0       7'h00
`define CLKMG_CW_FBMULT     7'h01
`define CLKMG_CW_INDIV      7'h02
`define CLKMG_CW_DUTY       7'h03
// reset values, in eighths for out0 and feedback, in hundredths for duty
`define CLKMG_RST_OUT0      16'h0008
`define CLKMG_RST_FBMULT    16'h0028
`define CLKMG_RST_INDIV     16'h0001
`define CLKMG_RST_DUTY      16'h0032
`define CLKMG_RST_OUTDIV    16'h0001
// limits
`define CLKMG_OUT_MAX       16'h0080
`define CLKMG_OUT0_FMIN     16'h0010
`define CLKMG_OUT0_FMAX     16'h0400
`define CLKMG_FB_MIN        16'h0010
`define CLKMG_FB_MAX        16'h0200
`define CLKMG_INDIV_MAX     16'h006A
`define CLKMG_DUTY_MIN      16'h0001
`define CLKMG_DUTY_MAX      16'h0063
`define CLKMG_PHASE_STEPS   16'h0038
// phase shift settle count and lock wait count
`define CLKMG_PS_SETTLE     4'h7
`define CLKMG_LOCK_CYCLES   8'h3F
`endif

// file: clkmg_pkg.sv
package clkmg_pkg;
	typedef enum logic [1:0] {CLKMG_PS_IDLE, CLKMG_PS_MOVE, CLKMG_PS_DONE} clkmg_ps_state_t;
	typedef enum logic [1:0] {CLKMG_CP_IDLE, CLKMG_CP_SHADOW, CLKMG_CP_APPLY} clkmg_cp_state_t;
endpackage : clkmg_pkg

// file: clkmg_cfg_port.sv
`timescale 1ns/1ps
`include "clkmg_regs.svh"
module clkmg_cfg_port (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// port request
	input  wire logic        reconfig_port_enable,
	input  wire logic        reconfig_write_enable,
	input  wire logic [6:0]  reconfig_address,
	input  wire logic [15:0] reconfig_write_data,
	// port answer
	output logic      [15:0] reconfig_read_data,
	output logic             reconfig_ready,
	// applied settings
	output logic      [15:0] out0_div,
	output logic      [15:0] fb_mult,
	output logic      [15:0] in_div,
	output logic      [15:0] duty_set
);
	logic [15:0] cfg_mem_reg [0:127];
	logic [15:0] shadow_reg, shadow_next;
	logic [6:0]  addr_reg, addr_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        rdy_reg, rdy_next;
	clkmg_pkg::clkmg_cp_state_t st_reg, st_next;

	// legality check; illegal words are refused but still answered
	function automatic logic word_ok(input logic [6:0] a, input logic [15:0] d);
		unique case (a)
			`CLKMG_CW_OUT0:   word_ok = (d[2:0] == 3'h0 && d >= 16'h0008 && d <= `CLKMG_OUT0_FMAX)
				|| (d >= `CLKMG_OUT0_FMIN && d <= `CLKMG_OUT0_FMAX); // RULE_10
			`CLKMG_CW_FBMULT: word_ok = d >= `CLKMG_FB_MIN && d <= `CLKMG_FB_MAX; // RULE_11
			`CLKMG_CW_INDIV:  word_ok = d >= 16'h0001 && d <= `CLKMG_INDIV_MAX; // RULE_12
			`CLKMG_CW_DUTY:   word_ok = d >= `CLKMG_DUTY_MIN && d <= `CLKMG_DUTY_MAX; // RULE_14
			default:          word_ok = (a < 7'h0A) ? (d >= 16'h0001 && d <= `CLKMG_OUT_MAX) : 1'b1; // RULE_08 RULE_09
		endcase
	endfunction : word_ok

	always_comb begin
		st_next     = st_reg;
		shadow_next = shadow_reg;
		addr_next   = addr_reg;
		rdata_next  = rdata_reg;
		rdy_next    = 1'b0;
		unique case (st_reg)
			clkmg_pkg::CLKMG_CP_IDLE: begin
				if (reconfig_port_enable) begin // RULE_01
					addr_next = reconfig_address; // RULE_24
					if (reconfig_write_enable) begin
						shadow_next = reconfig_write_data; // RULE_23
						st_next     = clkmg_pkg::CLKMG_CP_SHADOW;
					end else begin
						rdata_next = cfg_mem_reg[reconfig_address]; // RULE_21
						rdy_next   = 1'b1; // RULE_22
					end
				end
			end
			clkmg_pkg::CLKMG_CP_SHADOW: st_next = clkmg_pkg::CLKMG_CP_APPLY;
			clkmg_pkg::CLKMG_CP_APPLY: begin
				rdy_next = 1'b1; // RULE_22
				st_next  = clkmg_pkg::CLKMG_CP_IDLE;
			end
		endcase
	end

	// write lands three cycles after the request: shadow, then apply, then written with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin // RULE_25
			st_reg     <= clkmg_pkg::CLKMG_CP_IDLE;
			shadow_reg <= 16'h0000;
			addr_reg   <= 7'h00;
			rdata_reg  <= 16'h0000;
			rdy_reg    <= 1'b0;
		end else begin
			st_reg     <= st_next;
			shadow_reg <= shadow_next;
			addr_reg   <= addr_next;
			rdata_reg  <= rdata_next;
			rdy_reg    <= rdy_next;
		end
	end

	// memory has no reset; defaults load in the first apply-free cycles
	logic init_done_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done_reg <= 1'b0;
		end else begin
			init_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk) begin
		if (!init_done_reg) begin
			for (int i = 0; i < 128; i++) begin
				cfg_mem_reg[i] <= (i < 10) ? `CLKMG_RST_OUTDIV : 16'h0000;
			end
			cfg_mem_reg[`CLKMG_CW_OUT0]   <= `CLKMG_RST_OUT0;
			cfg_mem_reg[`CLKMG_CW_FBMULT] <= `CLKMG_RST_FBMULT;
			cfg_mem_reg[`CLKMG_CW_INDIV]  <= `CLKMG_RST_INDIV;
			cfg_mem_reg[`CLKMG_CW_DUTY]   <= `CLKMG_RST_DUTY;
		end else if (st_reg == clkmg_pkg::CLKMG_CP_APPLY && word_ok(addr_reg, shadow_reg)) begin
			cfg_mem_reg[addr_reg] <= shadow_reg; // RULE_23
		end
	end

	assign reconfig_read_data = rdata_reg;
	assign reconfig_ready     = rdy_reg;
	assign out0_div           = cfg_mem_reg[`CLKMG_CW_OUT0];
	assign fb_mult            = cfg_mem_reg[`CLKMG_CW_FBMULT];
	assign in_div             = cfg_mem_reg[`CLKMG_CW_INDIV];
	assign duty_set           = cfg_mem_reg[`CLKMG_CW_DUTY];

	chk_read_ready_next: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
		(st_reg == clkmg_pkg::CLKMG_CP_IDLE && reconfig_port_enable && !reconfig_write_enable) |=> reconfig_ready)
		else $error("read not answered in one cycle");
	chk_write_ready_three: assert property (@(posedge pclk) disable iff (!presetn) // RULE_23
		(st_reg == clkmg_pkg::CLKMG_CP_IDLE && reconfig_port_enable && reconfig_write_enable)
		|=> !reconfig_ready ##1 !reconfig_ready ##1 reconfig_ready)
		else $error("write ready not on third cycle");
	chk_read_data_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
		!reconfig_ready |-> $stable(reconfig_read_data))
		else $error("read data changed without operation");
	chk_ready_single: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
		reconfig_ready |=> !reconfig_ready)
		else $error("ready longer than one cycle");
	cov_cfg_write: cover property (@(posedge pclk) st_reg == clkmg_pkg::CLKMG_CP_APPLY);
endmodule : clkmg_cfg_port

// file: clkmg_ctrl.sv
`timescale 1ns/1ps
`include "clkmg_regs.svh"
// Contract
// RULE_01 - config port acts on rising clock edge
// RULE_02 - phase shift signals on rising clock edge
// RULE_03 - controller pulses shift enable one cycle
// RULE_04 - shift moves gradually, ends with done pulse
// RULE_05 - direction high increments, low decrements
// RULE_06 - accumulated phase wraps at full turn
// RULE_07 - done one cycle; next start after it
// RULE_08 - output dividers range one to 128
// RULE_09 - fractional only output zero and feedback
// RULE_10 - output zero divider integer or eighths
// RULE_11 - feedback multiplier two to 64, default five
// RULE_12 - input divider one to 106
// RULE_13 - phase offset in 56 steps per period
// RULE_14 - duty setting 0.01 to 0.99
// RULE_15 - inverted outputs complement outputs zero-three
// RULE_16 - input stopped flag sets fast, clears on lock
// RULE_17 - feedback stopped flag sets fast, clears on lock
// RULE_18 - lock rises automatically when aligned
// RULE_19 - lock falls within one cycle on fault
// RULE_20 - user resets device after lock loss
// RULE_21 - read returns addressed word, held after
// RULE_22 - ready pulse marks each completed operation
// RULE_23 - write data shadowed, applied later
// RULE_24 - seven-bit address selects 16-bit word
// RULE_25 - reset asynchronous, release synchronous
// RULE_26 - reference select changes only under reset
// RULE_27 - one port operation outstanding at most
module clkmg_ctrl (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// clock outputs status
	output logic      [3:0]  inverted_output_enables,
	output logic             reference_select
);
	logic [31:0] rdata_reg, rdata_next;
	logic        ctrl_rst_reg, ctrl_rst_next;
	logic        sel_reg, sel_next;
	logic        fbstop_src_reg, fbstop_src_next;
	logic        instop_src_reg, instop_src_next;
	logic [15:0] cfg_wdata_reg, cfg_wdata_next;
	logic [6:0]  cfg_addr_reg, cfg_addr_next;
	logic        cfg_we_reg, cfg_we_next;
	logic        cfg_en_reg, cfg_en_next;
	logic        cfg_busy_reg, cfg_busy_next;
	logic        ps_en_reg, ps_en_next;
	logic        ps_dir_reg, ps_dir_next;
	logic [5:0]  phase_reg, phase_next;
	logic [3:0]  ps_cnt_reg, ps_cnt_next;
	logic        ps_done_reg, ps_done_next;
	logic        instop_reg, instop_next;
	logic        fbstop_reg, fbstop_next;
	logic        lock_reg, lock_next;
	logic [7:0]  lock_cnt_reg, lock_cnt_next;
	clkmg_pkg::clkmg_ps_state_t ps_st_reg, ps_st_next;
	logic [15:0] cfg_rdata;
	logic        cfg_ready;
	logic [15:0] out0_div, fb_mult, in_div, duty_set;
	logic        wr_acc, rd_acc;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;

	clkmg_cfg_port u_cfg (
		.pclk                  (pclk),
		.presetn               (presetn),
		.reconfig_port_enable  (cfg_en_reg),
		.reconfig_write_enable (cfg_we_reg),
		.reconfig_address      (cfg_addr_reg),
		.reconfig_write_data   (cfg_wdata_reg),
		.reconfig_read_data    (cfg_rdata),
		.reconfig_ready        (cfg_ready),
		.out0_div              (out0_div),
		.fb_mult               (fb_mult),
		.in_div                (in_div),
		.duty_set              (duty_set)
	);

	// register writes and port launches
	always_comb begin
		ctrl_rst_next   = ctrl_rst_reg;
		sel_next        = sel_reg;
		fbstop_src_next = fbstop_src_reg;
		instop_src_next = instop_src_reg;
		cfg_wdata_next  = cfg_wdata_reg;
		cfg_addr_next   = cfg_addr_reg;
		cfg_we_next     = cfg_we_reg;
		cfg_en_next     = 1'b0;
		cfg_busy_next   = cfg_busy_reg && !cfg_ready;
		ps_en_next      = 1'b0;
		ps_dir_next     = ps_dir_reg;
		if (wr_acc) begin
			unique case (paddr)
				`CLKMG_OFF_CTRL: begin
					ctrl_rst_next   = pwdata[`CLKMG_CTRL_RST];
					// select only follows while held in reset
					if (ctrl_rst_reg) begin
						sel_next = pwdata[`CLKMG_CTRL_SEL]; // RULE_26
					end
					fbstop_src_next = pwdata[`CLKMG_CTRL_FBSTOP];
					instop_src_next = pwdata[`CLKMG_CTRL_INSTOP];
				end
				`CLKMG_OFF_PS: begin
					// start accepted only when idle, so one-cycle enable always
					// direction only under the same idle check, start bit set or not, so a shift in flight keeps its sense
					if (ps_st_reg == clkmg_pkg::CLKMG_PS_IDLE && !ps_en_reg) begin
						ps_en_next  = pwdata[`CLKMG_PS_START]; // RULE_03
						ps_dir_next = pwdata[`CLKMG_PS_DIR]; // RULE_05
					end
				end
				`CLKMG_OFF_CFG_DATA: cfg_wdata_next = pwdata[15:0];
				`CLKMG_OFF_CFG_ADDR: begin
					if (!cfg_busy_reg && pwdata[`CLKMG_CA_GO]) begin
						cfg_addr_next = pwdata[6:0]; // RULE_24
						cfg_we_next   = pwdata[`CLKMG_CA_WRITE];
						cfg_en_next   = 1'b1; // RULE_27
						cfg_busy_next = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// one fine step, wrapping at a full turn in both directions
	function automatic logic [5:0] phase_step(input logic dir, input logic [5:0] ph);
		logic [5:0] last;
		last = 6'(`CLKMG_PHASE_STEPS - 16'h0001);
		if (dir) begin
			phase_step = (ph == last) ? 6'h00 : ph + 6'h01; // RULE_06
		end else begin
			phase_step = (ph == 6'h00) ? last : ph - 6'h01; // RULE_13
		end
	endfunction : phase_step

	// fine phase shift; settle count stands in for the gradual move
	always_comb begin
		ps_st_next   = ps_st_reg;
		phase_next   = phase_reg;
		ps_cnt_next  = ps_cnt_reg;
		ps_done_next = 1'b0;
		unique case (ps_st_reg)
			clkmg_pkg::CLKMG_PS_IDLE: begin
				if (ps_en_reg) begin // RULE_02
					ps_st_next  = clkmg_pkg::CLKMG_PS_MOVE;
					ps_cnt_next = `CLKMG_PS_SETTLE;
				end
			end
			clkmg_pkg::CLKMG_PS_MOVE: begin
				ps_cnt_next = ps_cnt_reg - 4'h1; // RULE_04
				if (ps_cnt_reg == 4'h0) begin
					phase_next   = phase_step(ps_dir_reg, phase_reg); // RULE_05 RULE_06
					ps_done_next = 1'b1; // RULE_07
					ps_st_next   = clkmg_pkg::CLKMG_PS_DONE;
				end
			end
			clkmg_pkg::CLKMG_PS_DONE: ps_st_next = clkmg_pkg::CLKMG_PS_IDLE;
		endcase
	end

	// status flags; stop sources come from the FBSTOP and INSTOP bits of the ctrl register
	always_comb begin
		instop_next   = instop_reg;
		fbstop_next   = fbstop_reg;
		lock_next     = lock_reg;
		lock_cnt_next = lock_cnt_reg;
		if (ctrl_rst_reg || instop_src_reg || fbstop_src_reg) begin
			lock_next     = 1'b0; // RULE_19
			lock_cnt_next = 8'h00;
			instop_next   = instop_reg || instop_src_reg; // RULE_16
			fbstop_next   = fbstop_reg || fbstop_src_reg; // RULE_17
		end else if (lock_cnt_reg == `CLKMG_LOCK_CYCLES) begin
			lock_next   = 1'b1; // RULE_18
			instop_next = 1'b0;
			fbstop_next = 1'b0;
		end else begin
			lock_cnt_next = lock_cnt_reg + 8'h01;
		end
	end

	// apb read mux; unmapped reads zero
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_acc) begin
			unique case (paddr)
				`CLKMG_OFF_CTRL:     rdata_next = {28'h000_0000, instop_src_reg, fbstop_src_reg, sel_reg, ctrl_rst_reg};
				`CLKMG_OFF_STATUS:   rdata_next = {27'h000_0000, cfg_busy_reg, ps_st_reg != clkmg_pkg::CLKMG_PS_IDLE,
					fbstop_reg, instop_reg, lock_reg};
				`CLKMG_OFF_PS:       rdata_next = {30'h0000_0000, ps_dir_reg, 1'b0};
				`CLKMG_OFF_CFG_DATA: rdata_next = {16'h0000, cfg_wdata_reg};
				`CLKMG_OFF_CFG_ADDR: rdata_next = {16'h0000, cfg_rdata};
				`CLKMG_OFF_PHASE:    rdata_next = {26'h000_0000, phase_reg};
				default:             rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin // RULE_25
			rdata_reg      <= 32'h0000_0000;
			ctrl_rst_reg   <= 1'b0;
			sel_reg        <= 1'b1;
			fbstop_src_reg <= 1'b0;
			instop_src_reg <= 1'b0;
			cfg_wdata_reg  <= 16'h0000;
			cfg_addr_reg   <= 7'h00;
			cfg_we_reg     <= 1'b0;
			cfg_en_reg     <= 1'b0;
			cfg_busy_reg   <= 1'b0;
			ps_en_reg      <= 1'b0;
			ps_dir_reg     <= 1'b0;
			phase_reg      <= 6'h00;
			ps_cnt_reg     <= 4'h0;
			ps_done_reg    <= 1'b0;
			ps_st_reg      <= clkmg_pkg::CLKMG_PS_IDLE;
			instop_reg     <= 1'b0;
			fbstop_reg     <= 1'b0;
			lock_reg       <= 1'b0;
			lock_cnt_reg   <= 8'h00;
		end else begin
			rdata_reg      <= rdata_next;
			ctrl_rst_reg   <= ctrl_rst_next;
			sel_reg        <= sel_next;
			fbstop_src_reg <= fbstop_src_next;
			instop_src_reg <= instop_src_next;
			cfg_wdata_reg  <= cfg_wdata_next;
			cfg_addr_reg   <= cfg_addr_next;
			cfg_we_reg     <= cfg_we_next;
			cfg_en_reg     <= cfg_en_next;
			cfg_busy_reg   <= cfg_busy_next;
			ps_en_reg      <= ps_en_next;
			ps_dir_reg     <= ps_dir_next;
			phase_reg      <= phase_next;
			ps_cnt_reg     <= ps_cnt_next;
			ps_done_reg    <= ps_done_next;
			ps_st_reg      <= ps_st_next;
			instop_reg     <= instop_next;
			fbstop_reg     <= fbstop_next;
			lock_reg       <= lock_next;
			lock_cnt_reg   <= lock_cnt_next;
		end
	end

	assign prdata           = rdata_reg;
	assign pready           = 1'b1;
	assign pslverr          = 1'b0;
	assign reference_select = sel_reg;
	// inverted outputs only usable once locked
	assign inverted_output_enables = {4{lock_reg}}; // RULE_15

	chk_done_after_settle: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
		(ps_st_reg == clkmg_pkg::CLKMG_PS_IDLE && ps_en_reg) |=> !ps_done_reg [*8] ##1 ps_done_reg)
		else $error("done not nine cycles after start");
	chk_done_single: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
		ps_done_reg |=> !ps_done_reg)
		else $error("done longer than one cycle");
	chk_phase_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
		(ps_done_next && ps_dir_reg && phase_reg == 6'd55) |=> phase_reg == 6'h00)
		else $error("phase did not wrap");
	chk_lock_fall: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
		(instop_src_reg || fbstop_src_reg || ctrl_rst_reg) |=> !lock_reg)
		else $error("lock not dropped");
	chk_lock_rise: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
		(!lock_reg && !$past(lock_reg) && lock_cnt_reg == `CLKMG_LOCK_CYCLES && !ctrl_rst_reg
		&& !instop_src_reg && !fbstop_src_reg) |=> lock_reg)
		else $error("lock did not rise");
	chk_instop_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
		instop_src_reg |=> instop_reg)
		else $error("input stopped not flagged");
	chk_fbstop_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
		fbstop_src_reg |=> fbstop_reg)
		else $error("feedback stopped not flagged");
	chk_ps_one_cycle: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
		ps_en_reg |=> !ps_en_reg)
		else $error("shift enable longer than one cycle");
	chk_ps_start_refused: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
		(ps_st_reg != clkmg_pkg::CLKMG_PS_IDLE) |=> !ps_en_reg)
		else $error("shift started while busy");
	chk_cfg_busy_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
		cfg_ready |=> !cfg_busy_reg)
		else $error("config busy not cleared by ready");
	chk_cfg_launch_one: assert property (@(posedge pclk) disable iff (!presetn) // RULE_27
		cfg_en_reg |=> !cfg_en_reg)
		else $error("second config launch while busy");
	chk_sel_in_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE_26
		!ctrl_rst_reg |=> $stable(sel_reg))
		else $error("select changed outside reset");
	cov_ps_refused: cover property (@(posedge pclk) wr_acc && paddr == `CLKMG_OFF_PS
		&& ps_st_reg != clkmg_pkg::CLKMG_PS_IDLE);
	cov_ps_inc: cover property (@(posedge pclk) ps_done_reg && ps_dir_reg);
	cov_ps_dec: cover property (@(posedge pclk) ps_done_reg && !ps_dir_reg);
	cov_lock: cover property (@(posedge pclk) $rose(lock_reg));
endmodule : clkmg_ctrl

// file: clkmg_user_model.sv
`timescale 1ns/1ps
// user logic on the apb side, one transfer outstanding at a time
module clkmg_user_model (
	// clock
	input  wire logic        pclk,
	// apb request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	// apb answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	int gap = 0;
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
	end
	// entered just after a rising edge; returns just after one
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep the old value
		paddr   <= ~a;
		pwdata  <= ~wd;
		// idle gap stands for slow user logic
		repeat (gap + 1) @(posedge pclk);
	endtask : xfer
endmodule : clkmg_user_model

// file: clkmg_ctrl_test.sv
`timescale 1ns/1ps
`include "clkmg_regs.svh"
module clkmg_ctrl_test;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  ioe;
	logic        ref_sel;
	int          error_cnt;
	int          n_checks;
	logic [31:0] seed;
	logic [31:0] r;
	logic [15:0] q;
	logic [6:0]  a;
	logic [15:0] v;
	logic [5:0]  ph_exp;
	logic [15:0] exp_mem [0:9];
	logic [22:0] corner [0:15];

	clkmg_ctrl i_clkmg_ctrl (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.inverted_output_enables (ioe),
		.reference_select        (ref_sel)
	);
	clkmg_user_model i_user (
		.pclk    (pclk),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : nxt

	function automatic logic legal(input logic [6:0] wa, input logic [15:0] wv);
		case (wa)
			`CLKMG_CW_OUT0:   return wv == `CLKMG_RST_OUT0 || (wv >= `CLKMG_OUT0_FMIN && wv <= `CLKMG_OUT0_FMAX);
			`CLKMG_CW_FBMULT: return wv >= `CLKMG_FB_MIN && wv <= `CLKMG_FB_MAX;
			`CLKMG_CW_INDIV:  return wv >= 16'h0001 && wv <= `CLKMG_INDIV_MAX;
			`CLKMG_CW_DUTY:   return wv >= `CLKMG_DUTY_MIN && wv <= `CLKMG_DUTY_MAX;
			default:          return wv >= 16'h0001 && wv <= `CLKMG_OUT_MAX;
		endcase
	endfunction : legal

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic rd_reg(input logic [11:0] ra, output logic [31:0] d);
		i_user.xfer(1'b0, ra, 32'h0000_0000, d);
	endtask : rd_reg

	task automatic wr_reg(input logic [11:0] wa, input logic [31:0] d);
		logic [31:0] unused;
		i_user.xfer(1'b1, wa, d, unused);
	endtask : wr_reg

	// one config port operation, polled until the port is free again
	task automatic cfg(input logic wr, input logic [6:0] ca, input logic [15:0] d, output logic [15:0] qo);
		int n;
		n = 0;
		if (wr)
			wr_reg(`CLKMG_OFF_CFG_DATA, {16'h0000, d});
		wr_reg(`CLKMG_OFF_CFG_ADDR, {22'h00_0000, 1'b1, wr, 1'b0, ca});
		rd_reg(`CLKMG_OFF_STATUS, r);
		while (r[`CLKMG_ST_RDY] === 1'b1 && n < 50) begin
			rd_reg(`CLKMG_OFF_STATUS, r);
			n++;
		end
		check("config busy", 32'h0000_0000, {31'h0, r[`CLKMG_ST_RDY]});
		rd_reg(`CLKMG_OFF_CFG_ADDR, r);
		qo = r[15:0];
	endtask : cfg

	// dbl issues a second start while the first shift is still running
	task automatic shift(input logic dir, input logic dbl);
		int n;
		n = 0;
		wr_reg(`CLKMG_OFF_PS, {30'h0, dir, 1'b1});
		if (dbl)
			wr_reg(`CLKMG_OFF_PS, {30'h0, dir, 1'b1});
		rd_reg(`CLKMG_OFF_STATUS, r);
		while (r[`CLKMG_ST_PSBUSY] === 1'b1 && n < 50) begin
			rd_reg(`CLKMG_OFF_STATUS, r);
			n++;
		end
		if (dir)
			ph_exp = (ph_exp == 6'd55) ? 6'd0 : ph_exp + 6'd1;
		else
			ph_exp = (ph_exp == 6'd0) ? 6'd55 : ph_exp - 6'd1;
		rd_reg(`CLKMG_OFF_PHASE, r);
		check("phase", {26'h0, ph_exp}, r);
	endtask : shift

	task automatic wait_lock;
		int n;
		n = 0;
		rd_reg(`CLKMG_OFF_STATUS, r);
		while (r[`CLKMG_ST_LOCK] !== 1'b1 && n < 100) begin
			rd_reg(`CLKMG_OFF_STATUS, r);
			n++;
		end
		check("status", 32'h0000_0001, {27'h0, r[4:0]});
		check("inv enables", 32'h0000_000F, {28'h0, ioe});
	endtask : wait_lock

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		test_done();
	end

	initial begin
		presetn   = 1'b0;
		error_cnt = 0;
		n_checks  = 0;
		seed      = 32'h0001_7689;
		exp_mem   = '{`CLKMG_RST_OUT0, `CLKMG_RST_FBMULT, `CLKMG_RST_INDIV, `CLKMG_RST_DUTY, 16'h0001,
			16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
		// range edges, legal end values and illegal values just past the ranges
		corner    = '{23'h00_0008, 23'h00_0009, 23'h00_0010, 23'h00_0400, 23'h00_0401, 23'h01_000F,
			23'h01_0200, 23'h01_0201, 23'h02_0000, 23'h02_006A, 23'h02_006B, 23'h03_0063, 23'h03_0064,
			23'h04_0080, 23'h04_0081, 23'h09_0001};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		check("ref select", 32'h0000_0001, {31'h0, ref_sel});
		for (int i = 0; i < 10; i++) begin
			cfg(1'b0, i[6:0], 16'h0000, q);
			check("config word", {16'h0, exp_mem[i]}, {16'h0, q});
		end
		for (int i = 0; i < 28; i++) begin
			seed = nxt(seed);
			i_user.gap = int'(seed[19:18]);
			a = {3'h0, seed[31:28]} % 7'd10;
			v = seed[17] ? seed[15:0] : {6'h00, seed[9:0]};
			if (i < 16)
				{a, v} = corner[i];
			cfg(1'b1, a, v, q);
			if (legal(a, v))
				exp_mem[a] = v;
			cfg(1'b0, a, 16'h0000, q);
			check("config word", {16'h0, exp_mem[a]}, {16'h0, q});
		end
		wait_lock();
		for (int k = 0; k < 2; k++) begin
			// stop source set with the select bit kept high
			wr_reg(`CLKMG_OFF_CTRL, k ? 32'h0000_0006 : 32'h0000_000A);
			rd_reg(`CLKMG_OFF_STATUS, r);
			check("stopped status", k ? 32'h0000_0004 : 32'h0000_0002, {29'h0, r[2:0]});
			check("inv enables", 32'h0000_0000, {28'h0, ioe});
			wr_reg(`CLKMG_OFF_CTRL, 32'h0000_0003);
			wr_reg(`CLKMG_OFF_CTRL, 32'h0000_0002);
			wait_lock();
		end
		ph_exp = 6'd0;
		shift(1'b0, 1'b0);
		shift(1'b1, 1'b0);
		shift(1'b1, 1'b1);
		for (int i = 0; i < 8; i++) begin
			seed = nxt(seed);
			shift(seed[3], seed[4]);
		end
		wr_reg(12'h040, seed);
		rd_reg(12'h040, r);
		check("unmapped read", 32'h0000_0000, r);
		check("slave error", 32'h0000_0000, {31'h0, pslverr});
		// select is taken only while the hold-reset bit is already set
		for (int k = 0; k < 3; k++) begin
			wr_reg(`CLKMG_OFF_CTRL, {31'h0, k > 0});
			check("ref select", {31'h0, k < 2}, {31'h0, ref_sel});
		end
		presetn <= 1'b0;
		#1;
		check("ref select", 32'h0000_0001, {31'h0, ref_sel});
		check("read data", 32'h0000_0000, prdata);
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		cfg(1'b0, `CLKMG_CW_FBMULT, 16'h0000, q);
		check("config word", {16'h0, `CLKMG_RST_FBMULT}, {16'h0, q});
		rd_reg(`CLKMG_OFF_PHASE, r);
		check("phase", 32'h0000_0000, r);
		test_done();
	end
endmodule : clkmg_ctrl_test
